// ===== hw/pdc_protect.sv
// Supervision, protection trips, skip decision, zero-current turn-off, CV/CC codes and bleeders
//
// Local design decisions: register access over APB and the address map.
`default_nettype none
`include "pdc_map.svh"
module pdc_protect (
	// Clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	// Analog indications (asynchronous)
	input wire logic bias_lockout,
	input wire logic core_lockout,
	input wire logic gate_driver_supply_lockout,
	input wire logic ovp_comp,
	input wire logic uvp_comp,
	input wire logic [7:0] comp_node_level,
	input wire logic zcd_low_below,
	input wire logic zcd_high_below,
	input wire logic [9:0] out_current,
	// Control outputs
	output logic mcu_run,
	output logic pwm_enable,
	output logic pulse_skip_operation,
	output logic first_low_side_off,
	output logic second_high_side_off,
	output logic [7:0] ovp_trip_code,
	output logic [7:0] uvp_trip_code,
	output logic [8:0] cc_level_code,
	output logic [9:0] voltage_regulation_target,
	output logic bleeder_node_on
);
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	localparam int NS = 8;
	logic [NS-1:0] sync_a;
	logic [NS-1:0] sync_b;
	logic [7:0] comp_a;
	logic [7:0] comp_b;
	logic [9:0] cur_a;
	logic [9:0] cur_b;
	wire logic [NS-1:0] raw = {zcd_high_below, zcd_low_below, uvp_comp, ovp_comp,
		gate_driver_supply_lockout, core_lockout, bias_lockout, 1'b0};
	wire logic bias_s = sync_b[1];
	wire logic core_s = sync_b[2];
	wire logic gds_s = sync_b[3];
	wire logic ovp_s = sync_b[4];
	wire logic uvp_s = sync_b[5];
	wire logic zl_s = sync_b[6];
	wire logic zh_s = sync_b[7];

	// Two stages; multi-bit levels are slow analog codes so skew is tolerated
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_a <= 8'h0e;
			sync_b <= 8'h0e;
			comp_a <= 8'h00;
			comp_b <= 8'h00;
			cur_a <= 10'h000;
			cur_b <= 10'h000;
		end else if (clk_en) begin
			sync_a <= raw;
			sync_b <= sync_a;
			comp_a <= comp_node_level;
			comp_b <= comp_a;
			cur_a <= out_current;
			cur_b <= cur_a;
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [5:0] ctrl;
	logic [1:0] status;
	logic [1:0] mask;
	logic [1:0] ovp_deb_sel;
	logic [1:0] uvp_deb_sel;
	logic [7:0] skip_th;
	logic [9:0] cv_code;
	logic [7:0] cable_res;
	logic [9:0] cdc_off;
	logic ovp_hit;
	logic uvp_hit;
	wire logic wr = psel && penable && pwrite && clk_en;
	wire logic rd = psel && penable && !pwrite && clk_en;

	// Zero-wait slave: every access completes in its first access cycle
	assign pready = 1'b1;
	assign pslverr = 1'b0;

	// Software settings
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= 6'h00;
			mask <= 2'h0;
			ovp_trip_code <= `PDC_OVP_RST;
			uvp_trip_code <= `PDC_UVP_RST;
			ovp_deb_sel <= `PDC_DEB_RST;
			uvp_deb_sel <= `PDC_DEB_RST;
			skip_th <= `PDC_SKIP_RST;
			cc_level_code <= `PDC_CC_RST;
			cv_code <= `PDC_CV_RST;
			cable_res <= 8'h00;
		end else if (wr) begin
			case (paddr)
				`PDC_CTRL: ctrl <= pwdata[5:0];
				`PDC_MASK: mask <= pwdata[1:0];
				`PDC_OVP_TRIP: ovp_trip_code <= pwdata[7:0];
				`PDC_UVP_TRIP: uvp_trip_code <= pwdata[7:0];
				`PDC_DEBOUNCE: begin
					ovp_deb_sel <= pwdata[1:0];
					uvp_deb_sel <= pwdata[5:4];
				end
				`PDC_SKIP_TH: skip_th <= pwdata[7:0];
				`PDC_CC_LEVEL: cc_level_code <= pwdata[8:0];
				`PDC_CV_TARGET: cv_code <= pwdata[9:0];
				`PDC_CABLE_RES: cable_res <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	// Read mux; unmapped reads return zero
	always_comb begin
		prdata = 32'h0000_0000;
		case (paddr)
			`PDC_CTRL: prdata = {26'h0, ctrl};
			`PDC_STATUS: prdata = {28'h0, pwm_enable, mcu_run, status};
			`PDC_MASK: prdata = {30'h0, mask};
			`PDC_OVP_TRIP: prdata = {24'h0, ovp_trip_code};
			`PDC_UVP_TRIP: prdata = {24'h0, uvp_trip_code};
			`PDC_DEBOUNCE: prdata = {26'h0, uvp_deb_sel, 2'h0, ovp_deb_sel};
			`PDC_SKIP_TH: prdata = {24'h0, skip_th};
			`PDC_CC_LEVEL: prdata = {23'h0, cc_level_code};
			`PDC_CV_TARGET: prdata = {22'h0, cv_code};
			`PDC_CABLE_RES: prdata = {24'h0, cable_res};
			`PDC_OUT_CURR: prdata = {22'h0, cur_b};
			`PDC_STATE: prdata = {22'h0, voltage_regulation_target};
			default: prdata = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------
	// Debounce trips
	// ----------------------------------------
	// Debounce length in cycles: 1, 2, 4 or 8 base units
	function automatic logic [11:0] deb_len(input logic [1:0] sel);
		deb_len = 12'((`PDC_DEB_UNIT_CYC) << sel);
	endfunction

	logic [11:0] ovp_cnt;
	logic [11:0] uvp_cnt;
	pdc_pkg::pdc_deb_type ovp_st;
	pdc_pkg::pdc_deb_type uvp_st;

	// Bus over-voltage debounce
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ovp_st <= pdc_pkg::pdc_deb_idle;
			ovp_cnt <= 12'h000;
		end else if (clk_en) begin
			case (ovp_st)
				pdc_pkg::pdc_deb_idle: begin
					ovp_cnt <= 12'h001;
					if (ovp_s) ovp_st <= pdc_pkg::pdc_deb_count;
				end
				pdc_pkg::pdc_deb_count: begin
					if (!ovp_s) ovp_st <= pdc_pkg::pdc_deb_idle;
					else if (ovp_cnt >= deb_len(ovp_deb_sel)) ovp_st <= pdc_pkg::pdc_deb_trip;
					else ovp_cnt <= ovp_cnt + 12'h001;
				end
				pdc_pkg::pdc_deb_trip: ovp_st <= pdc_pkg::pdc_deb_idle;
				default: ovp_st <= pdc_pkg::pdc_deb_idle;
			endcase
		end
	end

	// Output under-voltage debounce, same shape with its own length
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			uvp_st <= pdc_pkg::pdc_deb_idle;
			uvp_cnt <= 12'h000;
		end else if (clk_en) begin
			case (uvp_st)
				pdc_pkg::pdc_deb_idle: begin
					uvp_cnt <= 12'h001;
					if (uvp_s) uvp_st <= pdc_pkg::pdc_deb_count;
				end
				pdc_pkg::pdc_deb_count: begin
					if (!uvp_s) uvp_st <= pdc_pkg::pdc_deb_idle;
					else if (uvp_cnt >= deb_len(uvp_deb_sel)) uvp_st <= pdc_pkg::pdc_deb_trip;
					else uvp_cnt <= uvp_cnt + 12'h001;
				end
				pdc_pkg::pdc_deb_trip: uvp_st <= pdc_pkg::pdc_deb_idle;
				default: uvp_st <= pdc_pkg::pdc_deb_idle;
			endcase
		end
	end

	assign ovp_hit = (ovp_st == pdc_pkg::pdc_deb_trip);
	assign uvp_hit = (uvp_st == pdc_pkg::pdc_deb_trip);

	// Sticky flags: trip wins over read-clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status <= 2'h0;
		end else if (clk_en) begin
			status[`PDC_ST_OVP] <= ovp_hit || (status[`PDC_ST_OVP] && !(rd && paddr == `PDC_STATUS));
			status[`PDC_ST_UVP] <= uvp_hit || (status[`PDC_ST_UVP] && !(rd && paddr == `PDC_STATUS));
		end
	end

	// Interrupt level from unmasked flags
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) irq <= 1'b0;
		else if (clk_en) irq <= |(status & mask);
	end

	// ----------------------------------------
	// Lockout, PWM gating, skip, zero current
	// ----------------------------------------
	// Held through the registered flags so PWM stays off until firmware clears them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mcu_run <= 1'b0;
			pwm_enable <= 1'b0;
			pulse_skip_operation <= 1'b0;
			first_low_side_off <= 1'b0;
			second_high_side_off <= 1'b0;
			bleeder_node_on <= 1'b0;
		end else if (clk_en) begin
			mcu_run <= !bias_s && !core_s;
			pwm_enable <= !bias_s && !core_s && !gds_s && ctrl[`PDC_CTRL_PWM_EN]
				&& !ovp_hit && !uvp_hit && status == 2'h0;
			pulse_skip_operation <= (comp_b < skip_th);
			first_low_side_off <= ctrl[`PDC_CTRL_DEM_EN] && zl_s;
			second_high_side_off <= ctrl[`PDC_CTRL_DEM_EN] && zh_s;
			bleeder_node_on <= ctrl[`PDC_CTRL_DOWN_TR] || ctrl[`PDC_CTRL_HARD_RST]
				|| ctrl[`PDC_CTRL_DETACH];
		end
	end

	// ----------------------------------------
	// Cable-drop compensation ramp
	// ----------------------------------------
	logic [13:0] step_cnt;
	wire logic [17:0] prod = {8'h00, cur_b} * {10'h000, cable_res};
	wire logic [9:0] cdc_goal = ctrl[`PDC_CTRL_CDC_EN] ? prod[17:8] : 10'h000;

	// One code step per interval keeps the output from jumping
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			step_cnt <= 14'h0000;
			cdc_off <= 10'h000;
		end else if (clk_en) begin
			if (step_cnt >= 14'(`PDC_CDC_STEP_CYC - 1)) begin
				step_cnt <= 14'h0000;
				if (cdc_off < cdc_goal) cdc_off <= cdc_off + 10'h001;
				else if (cdc_off > cdc_goal) cdc_off <= cdc_off - 10'h001;
			end else begin
				step_cnt <= step_cnt + 14'h0001;
			end
		end
	end

	// Saturating sum of target and offset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) voltage_regulation_target <= `PDC_CV_RST;
		else if (clk_en) voltage_regulation_target <= ({1'b0, cv_code} + {1'b0, cdc_off} > 11'h3ff)
			? 10'h3ff : 10'(cv_code + cdc_off);
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_mcu_lockout: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && (bias_s || core_s) |=> !mcu_run) else $error("mcu released in lockout");
	a_pwm_lockout: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && gds_s |=> !pwm_enable) else $error("pwm on with driver lockout");
	a_ovp_start: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && ovp_st == pdc_pkg::pdc_deb_idle && ovp_s |=> ovp_st == pdc_pkg::pdc_deb_count)
		else $error("ovp debounce did not start");
	a_ovp_flag: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && ovp_hit |=> status[`PDC_ST_OVP] && !pwm_enable) else $error("ovp trip lost");
	a_uvp_start: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && uvp_st == pdc_pkg::pdc_deb_idle && uvp_s |=> uvp_st == pdc_pkg::pdc_deb_count)
		else $error("uvp debounce did not start");
	a_uvp_flag: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && uvp_hit |=> status[`PDC_ST_UVP] && !pwm_enable) else $error("uvp trip lost");
	a_deb_restart: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && ovp_st == pdc_pkg::pdc_deb_count && !ovp_s |=> ovp_st == pdc_pkg::pdc_deb_idle)
		else $error("debounce not restarted");
	a_skip_mode: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && comp_b < skip_th |=> pulse_skip_operation) else $error("skip not entered");
	a_zcd_low: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && ctrl[`PDC_CTRL_DEM_EN] && zl_s |=> first_low_side_off) else $error("low side not off");
	a_bleed_on: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && ctrl[`PDC_CTRL_HARD_RST] |=> bleeder_node_on) else $error("bleeder off in reset");
	a_zcd_high: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && ctrl[`PDC_CTRL_DEM_EN] && zh_s |=> second_high_side_off) else $error("high side not off");
	a_uvp_restart: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && uvp_st == pdc_pkg::pdc_deb_count && !uvp_s |=> uvp_st == pdc_pkg::pdc_deb_idle)
		else $error("uvp debounce not restarted");
	a_flag_hold: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && status != 2'h0 |=> !pwm_enable) else $error("pwm on while a flag is set");
	// Release and exit directions, so an output stuck in its safe state is caught too
	a_mcu_release: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && !bias_s && !core_s |=> mcu_run) else $error("mcu held in lockout");
	a_skip_exit: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && comp_b >= skip_th |=> !pulse_skip_operation) else $error("skip kept above threshold");
	a_bleed_off: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && ctrl[5:3] == 3'h0 |=> !bleeder_node_on) else $error("bleeder on with no cause");
	// Offset may only move on a step boundary, which is what keeps the ramp gradual
	a_cdc_step: assert property (@(posedge pclk) disable iff (!presetn)
		step_cnt < 14'(`PDC_CDC_STEP_CYC - 1) |=> $stable(cdc_off))
		else $error("cable offset moved between steps");
endmodule
`default_nettype wire

// ===== hw/pdc_map.svh
// Offsets, field positions, reset values and timing counts of the converter protection control
`ifndef PDC_MAP_SVH
`define PDC_MAP_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PDC_CTRL 12'h000
`define PDC_STATUS 12'h004
`define PDC_MASK 12'h008
`define PDC_OVP_TRIP 12'h00c
`define PDC_UVP_TRIP 12'h010
`define PDC_DEBOUNCE 12'h014
`define PDC_SKIP_TH 12'h018
`define PDC_CC_LEVEL 12'h01c
`define PDC_CV_TARGET 12'h020
`define PDC_CABLE_RES 12'h024
`define PDC_OUT_CURR 12'h028
`define PDC_STATE 12'h02c
`define PDC_CLEAR 12'h030
// ----------------------------------------
// Field positions
// ----------------------------------------
`define PDC_CTRL_PWM_EN 0
`define PDC_CTRL_DEM_EN 1
`define PDC_CTRL_CDC_EN 2
`define PDC_CTRL_DOWN_TR 3
`define PDC_CTRL_HARD_RST 4
`define PDC_CTRL_DETACH 5
`define PDC_ST_OVP 0
`define PDC_ST_UVP 1
`define PDC_ST_MCU_UP 2
`define PDC_ST_PWM_UP 3
// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define PDC_OVP_RST 8'hff
`define PDC_UVP_RST 8'h00
`define PDC_DEB_RST 2'h1
`define PDC_SKIP_RST 8'h10
`define PDC_CC_RST 9'h100
`define PDC_CV_RST 10'h0d5
`define PDC_DEB_UNIT_NS 1000
`define PDC_CLK_NS 10
`define PDC_DEB_UNIT_CYC (`PDC_DEB_UNIT_NS / `PDC_CLK_NS)
`define PDC_CDC_STEP_NS 10000
`define PDC_CDC_STEP_CYC (`PDC_CDC_STEP_NS / `PDC_CLK_NS)
`endif

// ===== hw/pdc_pkg.sv
// Types shared by the converter protection control
`default_nettype none
package pdc_pkg;
	typedef enum logic [1:0] {pdc_deb_idle, pdc_deb_count, pdc_deb_trip} pdc_deb_type;
endpackage
`default_nettype wire

// ===== testbench/pdc_fw_model.sv
// Firmware-side APB master that issues one transfer at a time
`default_nettype none
module pdc_fw_model (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Command side
	input wire logic go,
	input wire logic wr,
	input wire logic [11:0] addr,
	input wire logic [31:0] wdata,
	output logic done,
	output logic [31:0] rdata,
	// APB master side
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----
	// Transfer sequencer
	// ----
	// Request held until pready; released bus lines flip so stale values never pass
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done <= 1'b0;
			rdata <= 32'h0;
			psel <= 1'b0;
			penable <= 1'b0;
			pwrite <= 1'b0;
			paddr <= 12'h0;
			pwdata <= 32'h0;
		end else begin
			done <= 1'b0;
			if (psel && penable && pready) begin
				rdata <= prdata;
				done <= 1'b1;
				psel <= 1'b0;
				penable <= 1'b0;
				paddr <= ~paddr;
				pwdata <= ~pwdata;
			end else if (psel) begin
				penable <= 1'b1;
			end else if (go) begin
				// Trip codes may be rewritten at any time
				psel <= 1'b1;
				pwrite <= wr;
				paddr <= addr;
				pwdata <= wdata;
			end
		end
	end
endmodule
`default_nettype wire

// ===== testbench/pd_converter_protection_control_tb.sv
// Self-checking bench for the converter protection control
`default_nettype none
`include "pdc_map.svh"
module pd_converter_protection_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'b0, presetn = 1'b0, go = 1'b0, wr = 1'b0, ce = 1'b1, done;
	logic psel, penable, pwrite, pready, irq, mcu_run, pwm_enable, skip, lo_off, hi_off, bleed;
	logic [11:0] addr = 12'h0, paddr;
	logic [31:0] wdata = 32'h0, rdata, pwdata, prdata;
	logic bias = 1'b1, core = 1'b1, gds = 1'b1, ovp = 1'b0, uvp = 1'b0, zl = 1'b0, zh = 1'b0;
	logic [7:0] level = 8'hff, ovp_code, uvp_code, th;
	logic [9:0] cur = 10'h0, target;
	logic [8:0] cc;
	logic [31:0] exp_q[$];
	int mismatches = 0, checks_done = 0, cycles = 0;
	pdc_protect DUT (.pclk(pclk), .presetn(presetn), .clk_en(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(),
		.irq(irq), .bias_lockout(bias), .core_lockout(core), .gate_driver_supply_lockout(gds),
		.ovp_comp(ovp), .uvp_comp(uvp), .comp_node_level(level), .zcd_low_below(zl), .zcd_high_below(zh),
		.out_current(cur), .mcu_run(mcu_run), .pwm_enable(pwm_enable), .pulse_skip_operation(skip),
		.first_low_side_off(lo_off), .second_high_side_off(hi_off), .ovp_trip_code(ovp_code),
		.uvp_trip_code(uvp_code), .cc_level_code(cc), .voltage_regulation_target(target),
		.bleeder_node_on(bleed));
	pdc_fw_model fw (.pclk(pclk), .presetn(presetn), .go(go), .wr(wr), .addr(addr), .wdata(wdata),
		.done(done), .rdata(rdata), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready));
	// ----
	// Clock, guard, read monitor
	// ----
	always #5 pclk = ~pclk;
	// Run takes about 6300 cycles, so this only cuts a hang
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 30000) begin
			mismatches++;
			give_verdict();
		end
	end
	// Empty queue forces a mismatch by comparing against the inverse
	always @(posedge pclk) begin
		if (done === 1'b1 && pwrite === 1'b0) check(rdata, exp_q.size() ? exp_q.pop_front() : ~rdata);
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		go <= 1'b1;
		wr <= w;
		addr <= a;
		wdata <= d;
		@(posedge pclk);
		go <= 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 50) begin
			@(posedge pclk);
			n++;
		end
		if (n == 50) mismatches++;
	endtask
	task automatic wreg(input logic [11:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask
	task automatic give_verdict();
		if (mismatches == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// ----
	// Scenarios
	// ----
	initial begin
		int i;
		logic [31:0] v;
		void'($urandom(32'h84ec708f));
		tick(8);
		presetn <= 1'b1;
		tick(2);
		check(ovp_code, `PDC_OVP_RST);
		check(uvp_code, `PDC_UVP_RST);
		check(cc, `PDC_CC_RST);
		check(target, `PDC_CV_RST);
		rd(`PDC_DEBOUNCE, 32'h11);
		rd(12'h100, 32'h0);
		// Lockouts released one by one
		bias <= 1'b0;
		tick(4);
		check(mcu_run, 1'b0);
		wreg(`PDC_CTRL, 32'h3);
		core <= 1'b0;
		tick(4);
		check({mcu_run, pwm_enable}, 2'b10);
		gds <= 1'b0;
		tick(4);
		check(pwm_enable, 1'b1);
		rd(`PDC_STATUS, 32'hc);
		// Over-voltage at 100 cycles, under-voltage at 200; second pass masked
		wreg(`PDC_DEBOUNCE, 32'h10);
		for (i = 0; i < 2; i++) begin
			wreg(`PDC_MASK, i ? 32'h1 : 32'h3);
			v = $urandom_range(255);
			wreg(i ? `PDC_UVP_TRIP : `PDC_OVP_TRIP, v);
			tick(2);
			check(i ? uvp_code : ovp_code, v[7:0]);
			{uvp, ovp} <= i ? 2'b10 : 2'b01;
			tick(i ? 150 : 90);
			{uvp, ovp} <= 2'b00;
			tick(4);
			check(pwm_enable, 1'b1);
			{uvp, ovp} <= i ? 2'b10 : 2'b01;
			tick(i ? 220 : 120);
			check({irq, pwm_enable}, {i == 0, 1'b0});
			{uvp, ovp} <= 2'b00;
			tick(4);
			check(pwm_enable, 1'b0);
			rd(`PDC_STATUS, i ? 32'h6 : 32'h5);
			tick(3);
			check({irq, pwm_enable}, 2'b01);
		end
		// Skip decision either side of a random threshold
		th = 8'($urandom_range(254, 1));
		wreg(`PDC_SKIP_TH, {24'h0, th});
		for (i = 0; i < 2; i++) begin
			level <= th - 8'(1 - i);
			tick(4);
			check(skip, i == 0);
		end
		// Zero-current turn-off, then with emulation off
		for (i = 0; i < 5; i++) begin
			{zh, zl} <= (i == 4) ? 2'b11 : 2'(i);
			if (i == 4) wreg(`PDC_CTRL, 32'h1);
			tick(4);
			check({hi_off, lo_off}, (i == 4) ? 2'b00 : 2'(i));
		end
		v = $urandom;
		wreg(`PDC_CC_LEVEL, v);
		wreg(`PDC_CV_TARGET, 32'h100);
		tick(2);
		check(cc, v[8:0]);
		check(target, 10'h100);
		// Offset of four codes ramps in one code per 1000 cycles
		cur <= 10'h010;
		wreg(`PDC_CABLE_RES, 32'h40);
		wreg(`PDC_CTRL, 32'h5);
		tick(2500);
		check(target > 10'h100 && target < 10'h104, 1'b1);
		tick(3000);
		check(target, 10'h104);
		rd(`PDC_STATE, 32'h104);
		rd(`PDC_OUT_CURR, 32'h10);
		// Each bleeder cause alone, then none
		for (i = 3; i < 7; i++) begin
			wreg(`PDC_CTRL, (i < 6) ? ((32'h1 << i) | 32'h1) : 32'h1);
			tick(3);
			check(bleed, i < 6);
		end
		// Frozen block must ignore a write that would turn a bleeder on
		ce <= 1'b0;
		wreg(`PDC_CTRL, 32'h11);
		ce <= 1'b1;
		tick(3);
		check(bleed, 1'b0);
		rd(`PDC_CTRL, 32'h1);
		give_verdict();
	end
endmodule
`default_nettype wire
